/* File: display_pkg.sv */
/*
 * shared constants, types and level functions of the segment display driver.
 * assumes one 125 MHz clock domain; no bus, all controls are plain ports.
 */
package display_pkg;

    localparam int NUM_SEG = 48;
    localparam int NUM_BP = 4;
    localparam int GROUP_W = 8;
    localparam int GROUP_BITS = 3;
    localparam int FRAME_DIV = 120;
    localparam int STEPS_PER_FRAME = 8;
    localparam int TICKS_PER_STEP = FRAME_DIV / STEPS_PER_FRAME;
    localparam logic [3:0] TICK_LAST = 4'(TICKS_PER_STEP - 1);
    localparam logic [3:0] TICK_ZERO = 4'h0;
    localparam logic [2:0] STEP_ZERO = 3'h0;
    localparam logic [2:0] STEP_ONE = 3'h1;
    localparam int SLAVE_BIT = 7;
    localparam int POL_BIT = 2;

    // drive levels: ground, 1/3, 2/3, full display supply
    localparam logic [1:0] LVL_GND = 2'h0;
    localparam logic [1:0] LVL_THIRD = 2'h1;
    localparam logic [1:0] LVL_TWO_THIRDS = 2'h2;
    localparam logic [1:0] LVL_FULL = 2'h3;

    // idle pattern of frame clock and sync pins
    localparam logic PIN_OFF = 1'h1;
    localparam logic CLK_ON_START = 1'h0;
    localparam logic SYNC_ON_START = 1'h1;

    typedef enum logic [1:0] {
        TM_IDLE = 2'b00,
        TM_RUN = 2'b01
    } timing_state_type;

    // backplane drive for the current step
    function automatic logic [1:0] bp_level(input logic sel, input logic pol);
        if (sel) begin
            bp_level = pol ? LVL_FULL : LVL_GND;
        end else begin
            bp_level = pol ? LVL_THIRD : LVL_TWO_THIRDS;
        end
    endfunction : bp_level

    // segment drive: full opposite swing for on, small swing for off
    function automatic logic [1:0] seg_level(input logic on, input logic pol);
        if (on) begin
            seg_level = pol ? LVL_GND : LVL_FULL;
        end else begin
            seg_level = pol ? LVL_TWO_THIRDS : LVL_THIRD;
        end
    endfunction : seg_level

endpackage : display_pkg

/* File: frame_if.sv */
/*
 * carrier between the display core and its frame timing generator.
 * assumes both ends share ref_clk_in.
 */
`timescale 1ns/100ps
`default_nettype none
interface frame_if;
    logic enable;
    logic slave;
    logic [2:0] step;
    modport timer (input enable, input slave, output step);
    modport user (output enable, output slave, input step);
endinterface : frame_if
`default_nettype wire

/* File: frame_timer.sv */
/*
 * frame timing: divides the selected input clock into 8 steps per frame,
 * or follows an external master's clock and sync in slave mode.
 * assumes lc and frame pins are synchronous to ref_clk_in.
 */
`timescale 1ns/100ps
`default_nettype none
module frame_timer
    import display_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    frame_if.timer frame,
    input wire logic frame_clock_option_in,
    input wire logic frame_clock_in,
    input wire logic frame_sync_in,
    output logic frame_clock_out,
    output logic frame_sync_out
);

    typedef struct packed {
        timing_state_type state;
        logic lc_prev;
        logic clkin_prev;
        logic [3:0] tick;
        logic [2:0] step;
        logic clk_o;
        logic sync_o;
    } timer_state_type;

    localparam timer_state_type TIMER_RESET = '{TM_IDLE, 1'b0, 1'b0, TICK_ZERO,
        STEP_ZERO, PIN_OFF, PIN_OFF};

    timer_state_type q_r;
    timer_state_type q_nxt;

    always_comb begin
        q_nxt = q_r;
        q_nxt.lc_prev = frame_clock_option_in;
        q_nxt.clkin_prev = frame_clock_in;
        if (!frame.enable) begin
            q_nxt.state = TM_IDLE;
            q_nxt.tick = TICK_ZERO;
            q_nxt.step = STEP_ZERO;
        end else begin
            case (q_r.state)
                TM_IDLE: begin
                    q_nxt.state = TM_RUN;
                end
                TM_RUN: begin
                    if (frame.slave) begin
                        // slave follows each change of the master clock
                        if (frame_clock_in != q_r.clkin_prev) begin
                            q_nxt.step = frame_sync_in ? STEP_ZERO : q_r.step + STEP_ONE;
                        end
                    end else if (frame_clock_option_in && !q_r.lc_prev) begin
                        // 15 input edges per step, 8 steps: 120 per frame
                        if (q_r.tick == TICK_LAST) begin
                            q_nxt.tick = TICK_ZERO;
                            q_nxt.step = q_r.step + STEP_ONE;
                        end else begin
                            q_nxt.tick = q_r.tick + 4'h1;
                        end
                    end
                end
                default: begin
                    q_nxt.state = TM_IDLE;
                end
            endcase
        end
        // master pins: 11 when off, 01 at switch-on, then running
        q_nxt.clk_o = (q_nxt.state == TM_RUN) ? q_nxt.step[0] : PIN_OFF;
        q_nxt.sync_o = (q_nxt.state == TM_RUN) ? (q_nxt.step == STEP_ZERO) : PIN_OFF;
    end

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            q_r <= TIMER_RESET;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign frame.step = q_r.step;
    assign frame_clock_out = q_r.clk_o;
    assign frame_sync_out = q_r.sync_o;

    sequence lc_edge_at_last_s;
        q_r.state == TM_RUN && frame.enable && !frame.slave && frame_clock_option_in
            && !q_r.lc_prev && q_r.tick == TICK_LAST;
    endsequence

    frame_divide_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        lc_edge_at_last_s |=> frame.step == $past(frame.step) + STEP_ONE)
        else $error("step did not advance after 15 input edges");

    master_off_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        !frame.enable |=> frame_clock_out && frame_sync_out)
        else $error("frame pins not 11 while off");

    master_on_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        frame.enable && q_r.state == TM_IDLE |=> !frame_clock_out && frame_sync_out)
        else $error("frame pins not 01 at switch-on");

endmodule : frame_timer
`default_nettype wire

/* File: segment_display.sv */
/*
 * 1:4 multiplexed segment display driver core: shadow and active segment
 * storage, load and slave select, standby control and level generation.
 * assumes an external level shifter turns each 2-bit level code into the
 * four analog drive voltages, and that software keeps its start-up order.
 */
// Operation
// - quarter multiplex: four backplanes, up to 48 segment lines in display mode.
// - each segment output takes ground, 1/3, 2/3 or full supply.
// - four-bit field per pin; bit n pairs with backplane n; set means on.
// - shadow bits copy into active storage together on a load write.
// - frame rate is selected input clock divided by 120.
// - after reset: standby, ports in port mode, not driving.
// - port in display mode during standby drives low.
// - enable flag starts all waveforms at once from loaded data.
// - while active, new data shows right after its load write.
// - clearing enable drives all ports low and returns to standby.
// - master always drives frame clock and sync outputs.
// - slave takes frame clock and sync from inputs instead.
// - segment on only with full opposite swings on backplane and segment.
// - load bit 7 writes slave select with the same load.
// - master shows 01 when on, 11 when off on clock and sync.
`timescale 1ns/100ps
`default_nettype none
module segment_display
    import display_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic seg_wr_in,
    input wire logic [1:0] seg_bank_in,
    input wire logic [GROUP_BITS-1:0] seg_group_in,
    input wire logic [GROUP_W-1:0] seg_data_in,
    input wire logic load_wr_in,
    input wire logic [7:0] load_data_in,
    input wire logic display_enable_flag_in,
    input wire logic slow_port_flag_in,
    input wire logic [NUM_SEG-1:0] seg_port_mode_in,
    input wire logic [NUM_BP-1:0] bp_port_mode_in,
    input wire logic frame_clock_option_in,
    input wire logic frame_clock_in,
    input wire logic frame_sync_in,
    output logic [2*NUM_SEG-1:0] seg_level_out,
    output logic [NUM_SEG-1:0] seg_oe_out,
    output logic [2*NUM_BP-1:0] bp_level_out,
    output logic [NUM_BP-1:0] bp_oe_out,
    output logic slow_edge_out,
    output logic slave_mode_out,
    output logic frame_clock_out,
    output logic frame_sync_out
);

    typedef struct packed {
        logic [NUM_BP-1:0][NUM_SEG-1:0] shadow;
        logic [NUM_BP-1:0][NUM_SEG-1:0] active;
        logic slave;
        logic slow;
        logic [NUM_SEG-1:0][1:0] seg_lvl;
        logic [NUM_BP-1:0][1:0] bp_lvl;
        logic [NUM_SEG-1:0] seg_oe;
        logic [NUM_BP-1:0] bp_oe;
    } core_state_type;

    core_state_type q_r;
    core_state_type q_nxt;

    frame_if frame ();

    frame_timer timer_u (
        .ref_clk_in(ref_clk_in),
        .resetn_in(resetn_in),
        .frame(frame.timer),
        .frame_clock_option_in(frame_clock_option_in),
        .frame_clock_in(frame_clock_in),
        .frame_sync_in(frame_sync_in),
        .frame_clock_out(frame_clock_out),
        .frame_sync_out(frame_sync_out)
    );

    // the timer gets the live flag so standby is entered the same cycle
    assign frame.enable = display_enable_flag_in;
    assign frame.slave = q_r.slave;

    always_comb begin
        logic pol;
        logic [1:0] bp_sel;
        pol = frame.step[POL_BIT];
        bp_sel = frame.step[1:0];
        q_nxt = q_r;
        q_nxt.slow = slow_port_flag_in;
        if (seg_wr_in) begin
            // bank picks the backplane bit of eight pins at once
            q_nxt.shadow[seg_bank_in][seg_group_in*GROUP_W +: GROUP_W] = seg_data_in;
        end
        if (load_wr_in) begin
            // one write moves every pin's field together, and sets the mode
            q_nxt.active = q_r.shadow;
            q_nxt.slave = load_data_in[SLAVE_BIT];
        end
        // port mode decides drive; reset leaves every port off
        q_nxt.seg_oe = seg_port_mode_in;
        q_nxt.bp_oe = bp_port_mode_in;
        for (int b = 0; b < NUM_BP; b++) begin
            // one backplane selected per step, polarity per half frame
            q_nxt.bp_lvl[b] = display_enable_flag_in && bp_port_mode_in[b]
                ? bp_level(bp_sel == 2'(b), pol) : LVL_GND;
        end
        for (int s = 0; s < NUM_SEG; s++) begin
            // current data shows, old data stays until the load
            q_nxt.seg_lvl[s] = display_enable_flag_in && seg_port_mode_in[s]
                ? seg_level(q_r.active[bp_sel][s], pol) : LVL_GND;
        end
    end

    // storage is not cleared: software must load before enabling
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            q_r.slave <= 1'b0;
            q_r.slow <= 1'b0;
            q_r.seg_lvl <= '0;
            q_r.bp_lvl <= '0;
            q_r.seg_oe <= '0;
            q_r.bp_oe <= '0;
        end else begin
            q_r.slave <= q_nxt.slave;
            q_r.slow <= q_nxt.slow;
            q_r.seg_lvl <= q_nxt.seg_lvl;
            q_r.bp_lvl <= q_nxt.bp_lvl;
            q_r.seg_oe <= q_nxt.seg_oe;
            q_r.bp_oe <= q_nxt.bp_oe;
        end
        q_r.shadow <= q_nxt.shadow;
        q_r.active <= q_nxt.active;
    end

    assign seg_level_out = q_r.seg_lvl;
    assign bp_level_out = q_r.bp_lvl;
    assign seg_oe_out = q_r.seg_oe;
    assign bp_oe_out = q_r.bp_oe;
    assign slow_edge_out = q_r.slow;
    assign slave_mode_out = q_r.slave;

    // helper: number of backplanes at a full-swing level
    function automatic int full_swing_count(input logic [NUM_BP-1:0][1:0] lv);
        full_swing_count = 0;
        for (int b = 0; b < NUM_BP; b++) begin
            if (lv[b] == LVL_GND || lv[b] == LVL_FULL) begin
                full_swing_count++;
            end
        end
    endfunction : full_swing_count

    sequence steady_enabled_s;
        display_enable_flag_in && (&bp_port_mode_in) ##1
            display_enable_flag_in && (&bp_port_mode_in);
    endsequence

    load_copy_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        load_wr_in |=> q_r.active == $past(q_r.shadow))
        else $error("active storage not loaded from shadow");

    slave_select_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        load_wr_in |=> slave_mode_out == $past(load_data_in[SLAVE_BIT]))
        else $error("slave select not taken from load bit 7");

    standby_low_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        !display_enable_flag_in |=> seg_level_out == '0 && bp_level_out == '0)
        else $error("ports not low in standby");

    mode_drive_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        1'b1 |=> seg_oe_out == $past(seg_port_mode_in) && bp_oe_out == $past(bp_port_mode_in))
        else $error("output enable does not follow port mode");

    reset_off_a: assert property (@(posedge ref_clk_in)
        !resetn_in |=> seg_oe_out == '0 && bp_oe_out == '0 && !slave_mode_out)
        else $error("ports driving or slave after reset");

    one_backplane_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        steady_enabled_s |=> full_swing_count(bp_level_out) == 1)
        else $error("not exactly one backplane at full swing");

    opposite_swing_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        display_enable_flag_in && seg_port_mode_in[0] && bp_port_mode_in[frame.step[1:0]]
        |=> seg_level_out[1:0] == ($past(q_r.active[frame.step[1:0]][0])
            ? ~bp_level_out[2*$past(frame.step[1:0]) +: 2]
            : ($past(frame.step[POL_BIT]) ? LVL_TWO_THIRDS : LVL_THIRD)))
        else $error("segment zero swing wrong against its backplane");

    shadow_write_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        seg_wr_in |=> q_r.shadow[$past(seg_bank_in)][$past(seg_group_in) * GROUP_W +: GROUP_W]
            == $past(seg_data_in))
        else $error("segment byte not written to its bank");

    slave_hold_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        !load_wr_in |=> slave_mode_out == $past(slave_mode_out))
        else $error("slave select changed without a load write");

    standby_port_low_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        !display_enable_flag_in && seg_port_mode_in[0] && bp_port_mode_in[0]
        |=> seg_oe_out[0] && bp_oe_out[0]
            && seg_level_out[1:0] == LVL_GND && bp_level_out[1:0] == LVL_GND)
        else $error("display mode port not low in standby");

    // standby holds the timer step at zero, so the first frame step is zero
    enable_start_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        $rose(display_enable_flag_in) && (&bp_port_mode_in)
        |=> full_swing_count(bp_level_out) == 1 && bp_level_out[1:0] == LVL_GND)
        else $error("waveforms not started on the first backplane at enable");

    bp_follow_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        steady_enabled_s |=> bp_level_out[2*$past(frame.step[1:0]) +: 2]
            == ($past(frame.step[POL_BIT]) ? LVL_FULL : LVL_GND))
        else $error("selected backplane does not follow the frame step");

    master_pins_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        display_enable_flag_in && $past(display_enable_flag_in) && $past(resetn_in)
        |-> frame_clock_out == frame.step[0] && frame_sync_out == (frame.step == STEP_ZERO))
        else $error("frame pins do not follow the frame step");

endmodule : segment_display
`default_nettype wire

/* File: ext_master_model.sv */
/*
 * external frame master model: drives frame clock and sync into a slave driver.
 * assumes the bench clock and a run level set by the bench.
 */
`timescale 1ns/100ps
`default_nettype none
module ext_master_model (
    input wire logic clk_in,
    input wire logic run_in,
    output logic clk_out,
    output logic sync_out,
    output logic [2:0] step_out
);
    logic [2:0] div_r;
    logic on_r;
    // a change only every 8 cycles, so the slave sees each one settled
    always @(posedge clk_in) begin
        on_r <= run_in;
        div_r <= div_r + 3'h1;
        if (!run_in || !on_r) begin
            clk_out <= !run_in; // 01 when on, 11 when off
            sync_out <= 1'b1;
            step_out <= 3'h0;
            div_r <= 3'h0;
        end else if (div_r == 3'h7) begin
            clk_out <= ~clk_out; // each change moves the slave on
            sync_out <= (step_out == 3'h7); // sync marks the frame start
            step_out <= step_out + 3'h1;
        end
    end
endmodule : ext_master_model
`default_nettype wire

/* File: segment_display_tb.sv */
/*
 * self-checking bench of the segment display driver against an integer model.
 * assumes display_pkg, frame_if, frame_timer and ext_master_model compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
module segment_display_tb
    import display_pkg::*;
;
    logic ref_clk_in = 1'b0, resetn_in = 1'b0, seg_wr_in = 1'b0, load_wr_in = 1'b0;
    logic display_enable_flag_in = 1'b0, slow_port_flag_in = 1'b0, master_run = 1'b0;
    logic frame_clock_option_in = 1'b0;
    logic [1:0] seg_bank_in = '0;
    logic [2:0] seg_group_in = '0;
    logic [7:0] seg_data_in = '0, load_data_in = '0;
    logic [47:0] seg_port_mode_in = '0;
    logic [3:0] bp_port_mode_in = '0;
    logic [95:0] seg_level_out;
    logic [47:0] seg_oe_out;
    logic [7:0] bp_level_out;
    logic [3:0] bp_oe_out;
    logic slow_edge_out, slave_mode_out, frame_clock_out, frame_sync_out, m_clk, m_sync;
    logic [2:0] m_step;
    int errors = 0, checks_done = 0, seed = 41, cyc_n = 0, sel_g, pol_g, t0, t1;
    int shd[4][48], act[4][48];
    bit seen[8];

    always #4 ref_clk_in = ~ref_clk_in;
    // option input toggles each cycle: one rising edge every 2 clocks
    always @(posedge ref_clk_in) begin
        cyc_n++;
        #1 frame_clock_option_in = ~frame_clock_option_in;
    end

    segment_display dut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
        .seg_wr_in(seg_wr_in), .seg_bank_in(seg_bank_in), .seg_group_in(seg_group_in),
        .seg_data_in(seg_data_in), .load_wr_in(load_wr_in), .load_data_in(load_data_in),
        .display_enable_flag_in(display_enable_flag_in),
        .slow_port_flag_in(slow_port_flag_in), .seg_port_mode_in(seg_port_mode_in),
        .bp_port_mode_in(bp_port_mode_in), .frame_clock_option_in(frame_clock_option_in),
        .frame_clock_in(m_clk), .frame_sync_in(m_sync), .seg_level_out(seg_level_out),
        .seg_oe_out(seg_oe_out), .bp_level_out(bp_level_out), .bp_oe_out(bp_oe_out),
        .slow_edge_out(slow_edge_out), .slave_mode_out(slave_mode_out),
        .frame_clock_out(frame_clock_out), .frame_sync_out(frame_sync_out));

    ext_master_model master (.clk_in(ref_clk_in), .run_in(master_run), .clk_out(m_clk),
        .sync_out(m_sync), .step_out(m_step));

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask : cyc

    task automatic check(input string what, input logic [63:0] got, input logic [63:0] want);
        checks_done++;
        if (got !== want) begin
            errors++;
            $display("mismatch %s expected %0h seen %0h", what, want, got);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // codes: 0 ground, 1 one third, 2 two thirds, 3 full supply
    task automatic check_levels(input int en);
        int e;
        sel_g = -1;
        pol_g = 0;
        for (int b = 0; b < 4; b++) begin
            if (bp_level_out[2*b+:2] === 2'h3 || bp_level_out[2*b+:2] === 2'h0) begin
                sel_g = b;
                pol_g = int'(bp_level_out[2*b+:2] === 2'h3);
            end
        end
        if (en != 0) begin
            check("bp_selected", 64'(sel_g < 0), 64'h0);
            if (sel_g >= 0) seen[sel_g + 4 * pol_g] = 1'b1;
        end
        for (int b = 0; b < 4; b++) begin
            e = (en == 0) ? 0 : (b == sel_g) ? 3 * pol_g : 2 - pol_g;
            check("bp_level", 64'(bp_level_out[2*b+:2]), 64'(e));
        end
        for (int s = 0; s < 48; s++) begin
            e = (en == 0 || !seg_port_mode_in[s]) ? 0 : 1 + pol_g;
            if (e != 0 && act[sel_g < 0 ? 0 : sel_g][s] != 0) e = 3 - 3 * pol_g;
            check("seg_level", 64'(seg_level_out[2*s+:2]), 64'(e));
        end
    endtask : check_levels

    task automatic fill_all();
        logic [7:0] d;
        for (int b = 0; b < 4; b++) begin
            for (int g = 0; g < 6; g++) begin
                d = 8'($random(seed));
                seg_bank_in = 2'(b);
                seg_group_in = 3'(g);
                seg_data_in = d;
                seg_wr_in = 1'b1;
                for (int i = 0; i < 8; i++) shd[b][g*8+i] = int'(d[i]);
                cyc(1);
            end
        end
        seg_wr_in = 1'b0;
    endtask : fill_all

    task automatic load(input logic [7:0] v);
        load_data_in = v;
        load_wr_in = 1'b1;
        act = shd;
        cyc(1);
        load_wr_in = 1'b0;
        cyc(1);
        check("slave_mode", 64'(slave_mode_out), 64'(v[7]));
        cyc(1);
    endtask : load

    task automatic sync_rise(output int t);
        logic p;
        for (int k = 0; k < 600; k++) begin
            p = frame_sync_out;
            cyc(1);
            if (p === 1'b0 && frame_sync_out === 1'b1) break;
        end
        t = cyc_n;
    endtask : sync_rise

    initial begin
        #(8 * 20000);
        errors++;
        give_verdict();
    end

    initial begin
        cyc(6);
        resetn_in = 1'b1;
        cyc(1);
        check_levels(0);
        check("oe_reset", 64'({seg_oe_out, bp_oe_out}), 64'h0);
        check("pins_off", 64'({frame_clock_out, frame_sync_out}), 64'h3);
        seg_port_mode_in = 48'({$random(seed), $random(seed)});
        bp_port_mode_in = 4'hf;
        slow_port_flag_in = 1'b1;
        cyc(1);
        check("oe_mode", 64'({seg_oe_out, bp_oe_out}), 64'({seg_port_mode_in, 4'hf}));
        check_levels(0);
        check("slow_edge", 64'(slow_edge_out), 64'h1);
        fill_all();
        load(8'h00);
        display_enable_flag_in = 1'b1;
        cyc(1);
        check_levels(1);
        cyc(1);
        check("pins_on", 64'({frame_clock_out, frame_sync_out}), 64'h1);
        for (int i = 0; i < 48; i++) begin
            cyc(5);
            check_levels(1);
        end
        for (int i = 0; i < 8; i++) check("bp_cover", 64'(seen[i]), 64'h1);
        fill_all();
        check_levels(1);
        load(8'h00);
        check_levels(1);
        sync_rise(t0);
        sync_rise(t1);
        check("frame_cycles", 64'(t1 - t0), 64'(2 * FRAME_DIV));
        display_enable_flag_in = 1'b0;
        cyc(1);
        check_levels(0);
        cyc(1);
        check("pins_off", 64'({frame_clock_out, frame_sync_out}), 64'h3);
        load(8'h80); // slave chosen here in standby; the 8'hff load later rewrites it while enabled
        master_run = 1'b1;
        cyc(2);
        display_enable_flag_in = 1'b1; // slave switched on after seeing 01
        for (int i = 0; i < 16; i++) begin
            t0 = int'(m_step);
            for (int k = 0; k < 20 && int'(m_step) == t0; k++) cyc(1);
            cyc(6);
            check_levels(1);
            check("slave_bp", 64'(sel_g), 64'(m_step[1:0]));
            check("slave_pol", 64'(pol_g), 64'(m_step[2]));
            if (i == 8) begin
                fill_all();
                load(8'hff);
            end
        end
        master_run = 1'b0;
        display_enable_flag_in = 1'b0;
        cyc(2);
        check_levels(0);
        give_verdict();
    end
endmodule : segment_display_tb
`default_nettype wire
